/* design/opm_inact_timer.sv */
`timescale 1ns/100ps
`default_nettype none
// Command inactivity timer: counts while armed, restarts on any activity
module opm_inact_timer #(
  parameter logic [opm_pkg::OPM_INACT_W-1:0] LIMIT =
    opm_pkg::OPM_INACT_W'(opm_pkg::OPM_INACT_CYCLES)
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // Control
  input  wire logic run,       // Timer armed
  input  wire logic restart,   // Activity seen, start over
  // Status
  output var  logic expired    // Level, high once limit reached
);

  logic [opm_pkg::OPM_INACT_W-1:0] cnt_reg;   // Elapsed cycles
  logic [opm_pkg::OPM_INACT_W-1:0] cnt_next;
  logic                            hit;       // Limit reached

  assign hit = (cnt_reg >= LIMIT - 28'h0000001);
  // Saturate at LIMIT - 1 so expiry stays asserted until disarmed or restarted
  assign cnt_next = (!run || restart) ? '0 :
                    hit ? cnt_reg : cnt_reg + 28'h0000001;

  // Counter and expiry flag
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_reg <= '0;
      expired <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      expired <= run && !restart && hit;
    end
  end

endmodule
`default_nettype wire

/* design/opm_power_fsm.sv */
`timescale 1ns/100ps
`default_nettype none
module opm_power_fsm #(
  parameter logic [opm_pkg::OPM_INACT_W-1:0] INACT_CYCLES =
    opm_pkg::OPM_INACT_W'(opm_pkg::OPM_INACT_CYCLES)
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // AXI4-Lite read data
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Supply and host pins
  input  wire logic        supply_ok,            // Main supply within range
  input  wire logic        power_control_input,  // One-cycle pin event from host
  input  wire logic        dtr_on,               // Data terminal ready level
  input  wire logic        rx_char,              // Serial character strobe
  // Network and activity events
  input  wire logic        t3324_expired,        // Active timer expiry pulse
  input  wire logic        t3412_expired,        // Periodic update timer pulse
  input  wire logic        edrx_sleep_window,    // Not listening for paging
  input  wire logic        edrx_paging_window,   // Paging occasion due
  input  wire logic        radio_activity,       // Radio traffic in progress
  input  wire logic        concurrent_busy,      // Other activity in progress
  // Power domain controls
  output var  logic        rtc_en,
  output var  logic        cpu_clk_min,
  output var  logic        cpu_clk_normal,
  output var  logic        rf_tx_en,
  output var  logic        rf_rx_en,
  output var  logic        app_if_en,
  output var  logic        rx_char_accept       // Character passed on to host path
);

  // State and configuration
  opm_pkg::opm_state_t state_reg;     // Current operating state
  opm_pkg::opm_state_t state_next;
  logic [opm_pkg::OPM_CTRL_WIDTH-1:0] ctrl_reg;      // Power saving config
  logic                               off_cmd_reg;   // Switch-off command pending
  logic [opm_pkg::OPM_WAKE_W-1:0]     wake_cnt_reg;  // Wake-up settle counter
  logic [opm_pkg::OPM_WAKE_W-1:0]     wake_cnt_next;
  logic                               wake_done_reg; // Wake-up complete

  // Bus side
  logic        aw_hs;         // Write address and data taken this cycle
  logic        ar_hs;         // Read address taken this cycle
  logic [3:0]  aw_addr_reg;   // Held write address
  logic [3:0]  ar_addr_reg;   // Held read address
  logic [31:0] w_data_reg;    // Held write data
  logic [3:0]  w_strb_reg;    // Held write strobes
  logic        wr_go_reg;     // Perform held write
  logic        rd_go_reg;     // Perform held read
  logic        wr_ctrl;       // Write hits control register
  logic        wr_cmd;        // Write hits command register
  logic        wr_hit;        // Write address decoded
  logic        rd_ctrl;
  logic        rd_stat;
  logic        rd_hit;
  logic [31:0] rd_data;       // Read mux
  logic [31:0] stat_word;     // Status register view

  // Configuration decode
  logic [2:0]  idle_cfg;
  logic        psm_en;
  logic        edrx_en;
  logic        inact_run;     // Inactivity timer armed
  logic        inact_exp;     // Inactivity timer expired
  logic        auto_ok;       // No concurrent activity
  logic        st_active;
  logic        st_idle;
  logic        st_deep;
  logic        st_off;

  // Timer: only counts in active with a config that uses it
  opm_inact_timer #(
    .LIMIT   (INACT_CYCLES)
  ) u_inact (
    .mclk    (mclk),
    .rstn    (rstn),
    .run     (inact_run),
    .restart (rx_char || wr_go_reg),
    .expired (inact_exp)
  );

  // Configuration fields
  assign psm_en    = ctrl_reg[opm_pkg::OPM_CTRL_PSM_BIT];
  assign idle_cfg  = ctrl_reg[opm_pkg::OPM_CTRL_IDLE_MSB:opm_pkg::OPM_CTRL_IDLE_LSB];
  assign edrx_en   = ctrl_reg[opm_pkg::OPM_CTRL_EDRX_BIT];
  assign st_active = (state_reg == opm_pkg::OPM_ACTIVE);
  assign st_idle   = (state_reg == opm_pkg::OPM_IDLE);
  assign st_deep   = (state_reg == opm_pkg::OPM_DEEP_SLEEP);
  assign st_off    = (state_reg == opm_pkg::OPM_POWER_OFF);
  assign inact_run = st_active &&
                     (idle_cfg == opm_pkg::OPM_IDLE_DEEP || idle_cfg == opm_pkg::OPM_IDLE_RXWK);
  // Radio traffic counts as concurrent activity too
  assign auto_ok   = !concurrent_busy && !radio_activity;

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      opm_pkg::OPM_NOT_POWERED: begin
        // Supply alone never switches the module on
        if (supply_ok) state_next = opm_pkg::OPM_POWER_OFF;
      end
      opm_pkg::OPM_POWER_OFF: begin
        if (power_control_input) state_next = opm_pkg::OPM_ACTIVE;
        else state_next = opm_pkg::OPM_POWER_OFF;
      end
      opm_pkg::OPM_DEEP_SLEEP: begin
        // Any wake source returns to active
        if (t3412_expired) state_next = opm_pkg::OPM_ACTIVE;
        else if (edrx_en && edrx_paging_window) begin
          state_next = opm_pkg::OPM_ACTIVE;
        end else if (power_control_input) state_next = opm_pkg::OPM_ACTIVE;
      end
      opm_pkg::OPM_IDLE: begin
        // Wake by terminal-ready or first serial character
        if (idle_cfg == opm_pkg::OPM_IDLE_DTR && dtr_on) begin
          state_next = opm_pkg::OPM_ACTIVE;
        end else if (idle_cfg == opm_pkg::OPM_IDLE_RXWK && rx_char) begin
          state_next = opm_pkg::OPM_ACTIVE;
        end else if (idle_cfg != opm_pkg::OPM_IDLE_DTR &&
                     idle_cfg != opm_pkg::OPM_IDLE_RXWK) begin
          state_next = opm_pkg::OPM_ACTIVE;
        end
      end
      opm_pkg::OPM_ACTIVE: begin
        // Host shutdown takes priority over any automatic move
        if (off_cmd_reg || power_control_input) begin
          state_next = opm_pkg::OPM_POWER_OFF;
        end else if (radio_activity) state_next = opm_pkg::OPM_CONNECTED;
        else if (auto_ok && psm_en && t3324_expired) begin
          state_next = opm_pkg::OPM_DEEP_SLEEP;
        end else if (auto_ok && idle_cfg == opm_pkg::OPM_IDLE_DEEP && inact_exp) begin
          state_next = opm_pkg::OPM_DEEP_SLEEP;
        end else if (auto_ok && edrx_en && edrx_sleep_window) begin
          state_next = opm_pkg::OPM_DEEP_SLEEP;
        end else if (auto_ok && idle_cfg == opm_pkg::OPM_IDLE_DTR && !dtr_on) begin
          state_next = opm_pkg::OPM_IDLE;
        end else if (auto_ok && idle_cfg == opm_pkg::OPM_IDLE_RXWK && inact_exp) begin
          state_next = opm_pkg::OPM_IDLE;
        end
      end
      opm_pkg::OPM_CONNECTED: begin
        if (!radio_activity) state_next = opm_pkg::OPM_ACTIVE;
      end
      default: state_next = opm_pkg::OPM_NOT_POWERED;
    endcase
    // Supply loss overrides everything, power-off included
    if (!supply_ok) state_next = opm_pkg::OPM_NOT_POWERED;
  end

  // Wake-up settle time after leaving idle; characters wait for it
  assign wake_cnt_next = (st_idle || state_next != opm_pkg::OPM_ACTIVE) ? '0 :
                         (wake_cnt_reg == opm_pkg::OPM_WAKE_W'(opm_pkg::OPM_WAKE_CYCLES)) ?
                         wake_cnt_reg : wake_cnt_reg + 6'h01;

  // State register, one-hot
  always_ff @(posedge mclk) begin
    if (!rstn) state_reg <= opm_pkg::OPM_NOT_POWERED;
    else state_reg <= state_next;
  end

  // Wake tracking
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wake_cnt_reg  <= '0;
      wake_done_reg <= 1'b0;
    end else begin
      wake_cnt_reg  <= wake_cnt_next;
      wake_done_reg <= (wake_cnt_next == opm_pkg::OPM_WAKE_W'(opm_pkg::OPM_WAKE_CYCLES));
    end
  end

  // Power domain outputs, registered from the next state so they match state_reg
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rtc_en         <= 1'b0;
      cpu_clk_min    <= 1'b0;
      cpu_clk_normal <= 1'b0;
      rf_tx_en       <= 1'b0;
      rf_rx_en       <= 1'b0;
      app_if_en      <= 1'b0;
    end else begin
      // Real-time clock runs in every switched-on state
      rtc_en         <= (state_next != opm_pkg::OPM_NOT_POWERED) &&
                        (state_next != opm_pkg::OPM_POWER_OFF);
      cpu_clk_min    <= (state_next == opm_pkg::OPM_IDLE);
      cpu_clk_normal <= (state_next == opm_pkg::OPM_ACTIVE) ||
                        (state_next == opm_pkg::OPM_CONNECTED);
      rf_tx_en       <= (state_next == opm_pkg::OPM_CONNECTED);
      rf_rx_en       <= (state_next == opm_pkg::OPM_CONNECTED);
      // Interfaces stay reachable in idle so the host can wake it
      app_if_en      <= (state_next == opm_pkg::OPM_ACTIVE) ||
                        (state_next == opm_pkg::OPM_CONNECTED) ||
                        (state_next == opm_pkg::OPM_IDLE);
    end
  end

  // Serial characters pass only once fully awake; the waking one is dropped
  always_ff @(posedge mclk) begin
    if (!rstn) rx_char_accept <= 1'b0;
    else rx_char_accept <= rx_char && wake_done_reg &&
                           (st_active || state_reg == opm_pkg::OPM_CONNECTED);
  end

  // Bus handshakes: one outstanding write and one read at a time
  assign aw_hs = s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                 !wr_go_reg && !s_axi_bvalid;
  assign ar_hs = s_axi_arvalid && !s_axi_arready && !rd_go_reg && !s_axi_rvalid;

  // Address decode
  assign wr_ctrl = (aw_addr_reg == opm_pkg::OPM_CTRL_OFS);
  assign wr_cmd  = (aw_addr_reg == opm_pkg::OPM_CMD_OFS);
  assign wr_hit  = wr_ctrl || wr_cmd;
  assign rd_ctrl = (ar_addr_reg == opm_pkg::OPM_CTRL_OFS);
  assign rd_stat = (ar_addr_reg == opm_pkg::OPM_STATUS_OFS);
  assign rd_hit  = rd_ctrl || rd_stat || (ar_addr_reg == opm_pkg::OPM_CMD_OFS);

  // Status view of the live state
  assign stat_word = {22'h000000, app_if_en, wake_done_reg, 2'h0, state_reg};
  assign rd_data   = rd_ctrl ? {27'h0000000, ctrl_reg} :
                     rd_stat ? stat_word : 32'h00000000;

  // Write path: ready pulses one cycle, write acts in that same cycle, response after
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      wr_go_reg     <= 1'b0;
      aw_addr_reg   <= 4'h0;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
    end else begin
      s_axi_awready <= aw_hs;
      s_axi_wready  <= aw_hs;
      wr_go_reg     <= aw_hs;
      if (aw_hs) begin
        aw_addr_reg <= {s_axi_awaddr[3:2], 2'h0};
        w_data_reg  <= s_axi_wdata;
        w_strb_reg  <= s_axi_wstrb;
      end
    end
  end

  // Write response
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= opm_pkg::OPM_RESP_OKAY;
    end else if (wr_go_reg) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? opm_pkg::OPM_RESP_OKAY : opm_pkg::OPM_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register, low byte lane only
  always_ff @(posedge mclk) begin
    if (!rstn) ctrl_reg <= opm_pkg::OPM_CTRL_RESET;
    else if (wr_go_reg && wr_ctrl && w_strb_reg[0]) begin
      ctrl_reg <= w_data_reg[opm_pkg::OPM_CTRL_WIDTH-1:0];
    end
  end

  // Switch-off command: held until acted on or no longer meaningful
  always_ff @(posedge mclk) begin
    if (!rstn) off_cmd_reg <= 1'b0;
    else if (wr_go_reg && wr_cmd && w_strb_reg[0] &&
             w_data_reg[opm_pkg::OPM_CMD_OFF_BIT]) begin
      off_cmd_reg <= 1'b1;
    end else if (!st_active || st_off) begin
      off_cmd_reg <= 1'b0;
    end
  end

  // Read path
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      rd_go_reg     <= 1'b0;
      ar_addr_reg   <= 4'h0;
    end else begin
      s_axi_arready <= ar_hs;
      rd_go_reg     <= ar_hs;
      if (ar_hs) ar_addr_reg <= {s_axi_araddr[3:2], 2'h0};
    end
  end

  // Read data and response
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= opm_pkg::OPM_RESP_OKAY;
    end else if (rd_go_reg) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_hit ? opm_pkg::OPM_RESP_OKAY : opm_pkg::OPM_RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* dv/opm_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Host processor side of the power control pin
module opm_host_model (
  // Clock
  input  wire logic mclk,
  // Pin toward the module
  output var  logic power_control_input
);
  initial power_control_input = 1'b0;
  // One-cycle pin event; a long wait models a slow host
  task automatic press(input int unsigned wait_cycles);
    repeat (wait_cycles) @(posedge mclk);
    power_control_input <= 1'b1;
    @(posedge mclk);
    power_control_input <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* dv/opm_power_fsm_sva.sv */
`timescale 1ns/100ps
`default_nettype none
// Ties each power domain control except the idle clock to the event that caused it
module opm_fsm_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Supply, host and network events
  input wire logic supply_ok,
  input wire logic power_control_input,
  input wire logic rx_char,
  input wire logic t3412_expired,
  input wire logic edrx_paging_window,
  input wire logic radio_activity,
  input wire logic concurrent_busy,
  // Write response, may carry a switch-off command
  input wire logic s_axi_bvalid,
  // Power domain controls
  input wire logic rtc_en,
  input wire logic cpu_clk_min,
  input wire logic cpu_clk_normal,
  input wire logic rf_tx_en,
  input wire logic rf_rx_en,
  input wire logic app_if_en,
  input wire logic rx_char_accept
);
  default clocking opm_cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // State decodes from the outputs, the state register is not a port
  sequence active_s;
    cpu_clk_normal && !rf_tx_en && app_if_en;
  endsequence
  sequence deep_s;
    rtc_en && !cpu_clk_min && !cpu_clk_normal && !rf_tx_en;
  endsequence
  // Nothing that outranks an automatic move is pending
  sequence calm_s;
    supply_ok && !power_control_input && !s_axi_bvalid;
  endsequence

  power_loss_a: assert property (
    !supply_ok |=> !rtc_en && !cpu_clk_normal && !cpu_clk_min && !rf_tx_en && !app_if_en)
    else $error("outputs stayed on after supply loss");
  stay_down_a: assert property (
    !rtc_en && !power_control_input |=> !rtc_en && !app_if_en && !cpu_clk_normal)
    else $error("left a powered-down state without the power pin");
  switch_on_a: assert property (
    !rtc_en && power_control_input && supply_ok && $past(supply_ok) && $past(rstn)
    |=> active_s) else $error("power pin did not switch on from power-off");
  sleep_quiet_a: assert property (
    rtc_en && !cpu_clk_normal && !cpu_clk_min && !rf_tx_en |-> !app_if_en && !rf_rx_en)
    else $error("deep-sleep left interfaces or radio on");
  idle_clock_a: assert property (
    cpu_clk_min |-> !cpu_clk_normal && rtc_en && !rf_tx_en)
    else $error("idle clock overlaps another mode");
  rf_pair_a: assert property (
    rf_tx_en == rf_rx_en) else $error("radio paths enabled apart");
  connect_a: assert property (
    active_s ##0 calm_s ##0 radio_activity |=> rf_tx_en && rf_rx_en)
    else $error("radio traffic did not connect");
  busy_hold_a: assert property (
    active_s ##0 calm_s ##0 (concurrent_busy && !radio_activity) |=> active_s)
    else $error("left active while busy");
  wake_a: assert property (
    deep_s ##0 supply_ok ##0 (t3412_expired || power_control_input || edrx_paging_window)
    |=> active_s) else $error("deep-sleep did not wake");
  first_char_a: assert property (
    cpu_clk_min && rx_char |=> !rx_char_accept) else $error("waking character passed on");
  accept_cause_a: assert property (
    rx_char_accept |-> $past(rx_char)) else $error("accept without a character");
endmodule

bind opm_power_fsm opm_fsm_sva opm_fsm_sva_i (.mclk(mclk), .rstn(rstn),
  .supply_ok(supply_ok), .power_control_input(power_control_input), .rx_char(rx_char),
  .t3412_expired(t3412_expired), .edrx_paging_window(edrx_paging_window),
  .radio_activity(radio_activity), .concurrent_busy(concurrent_busy),
  .s_axi_bvalid(s_axi_bvalid), .rtc_en(rtc_en), .cpu_clk_min(cpu_clk_min),
  .cpu_clk_normal(cpu_clk_normal), .rf_tx_en(rf_tx_en), .rf_rx_en(rf_rx_en),
  .app_if_en(app_if_en), .rx_char_accept(rx_char_accept));
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the operating mode sequencer
module tb;
  // Expected read word, mask of checked bits, response
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} opm_rexp_t;
  localparam logic [27:0] INACT = 28'h000003C;  // Short stand-in for 6 s
  localparam int          GAP   = 75;           // Safely past the inactivity limit
  // Clock, reset, bus master
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pwr, rx_acc;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  // Pins and network events; terminal-ready starts ON
  logic        supply_ok = 1'b0, dtr_on = 1'b1, radio = 1'b0, busy = 1'b0;
  logic        rx_char = 1'b0, page_w = 1'b0, sleep_w = 1'b0, t3324 = 1'b0, t3412 = 1'b0;
  // Scoreboard queues and counters
  opm_rexp_t   rq[$];
  logic [1:0]  bq[$];
  int          n_fail = 0, comparisons = 0, cyc = 0, n_acc = 0;

  always #12.5 mclk = ~mclk;

  opm_power_fsm #(.INACT_CYCLES(INACT)) opm_power_fsm_i (.mclk(mclk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .supply_ok(supply_ok), .power_control_input(pwr), .dtr_on(dtr_on), .rx_char(rx_char),
    .t3324_expired(t3324), .t3412_expired(t3412), .edrx_sleep_window(sleep_w),
    .edrx_paging_window(page_w), .radio_activity(radio), .concurrent_busy(busy),
    .rtc_en(), .cpu_clk_min(), .cpu_clk_normal(), .rf_tx_en(), .rf_rx_en(), .app_if_en(),
    .rx_char_accept(rx_acc));
  opm_host_model opm_host_model_i (.mclk(mclk), .power_control_input(pwr));

  // Verdict and end of run
  task automatic results();
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Compare a read answer with its note
  task automatic chk_rd(input opm_rexp_t e);
    comparisons++;
    if (((rdata & e.m) !== e.d) || (rresp !== e.r)) begin
      n_fail++;
      $display("unexpected at %0t: read %h/%h, want %h/%h", $time, rdata, rresp, e.d, e.r);
    end
  endtask
  // Compare a write response with its note
  task automatic chk_b(input logic [1:0] e);
    comparisons++;
    if (bresp !== e) begin
      n_fail++;
      $display("unexpected at %0t: write response %h, want %h", $time, bresp, e);
    end
  endtask
  // Compare a count kept by the bench
  task automatic chk_n(input int got, input int want);
    comparisons++;
    if (got != want) begin
      n_fail++;
      $display("unexpected at %0t: count %0d, want %0d", $time, got, want);
    end
  endtask
  // Watcher: takes the oldest note whenever an answer is handed over; also the hang limit
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rx_acc === 1'b1) n_acc++;
    if (rvalid && rready) chk_rd(rq.pop_front());
    if (bvalid && bready) chk_b(bq.pop_front());
    if (cyc == 8000) begin
      n_fail++;
      results();
    end
  end

  task automatic gap(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    bq.push_back(er);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (!bvalid);
    bready <= 1'b0;
  endtask
  // Read with a note of the expected answer
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] er);
    rq.push_back('{d, m, er});
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    rready <= 1'b0;
  endtask
  // State read back; wake-done bit is left out of the check
  task automatic st(input opm_pkg::opm_state_t s);
    logic [31:0] e;
    e = 32'h00000000;
    e[5:0] = s;
    e[opm_pkg::OPM_STAT_IF_BIT] = s inside {opm_pkg::OPM_IDLE, opm_pkg::OPM_ACTIVE,
                                            opm_pkg::OPM_CONNECTED};
    rd(opm_pkg::OPM_STATUS_OFS, e, 32'hFFFFFEFF, opm_pkg::OPM_RESP_OKAY);
  endtask
  // One-cycle event: 0 char, 1 paging, 2 sleep window, 3 active timer, 4 update timer
  task automatic ev(input int k);
    {t3412, t3324, sleep_w, page_w, rx_char} <= 5'(1 << k);
    @(posedge mclk);
    {t3412, t3324, sleep_w, page_w, rx_char} <= 5'h00;
  endtask
  task automatic on_pin();
    opm_host_model_i.press($urandom_range(0, 9));
    gap(2);
  endtask

  initial begin
    void'($urandom(19));
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    st(opm_pkg::OPM_NOT_POWERED);
    rd(4'hC, 32'h00000000, 32'hFFFFFFFF, opm_pkg::OPM_RESP_DECERR);
    rd(opm_pkg::OPM_CTRL_OFS, 32'h00000000, 32'hFFFFFFFF, opm_pkg::OPM_RESP_OKAY);
    rd(opm_pkg::OPM_CMD_OFS, 32'h00000000, 32'hFFFFFFFF, opm_pkg::OPM_RESP_OKAY);
    wr(4'hC, 32'h00000001, opm_pkg::OPM_RESP_DECERR);
    supply_ok <= 1'b1;
    gap(3 + $urandom_range(0, 20));
    st(opm_pkg::OPM_POWER_OFF);
    supply_ok <= 1'b0;
    gap(2);
    st(opm_pkg::OPM_NOT_POWERED);
    supply_ok <= 1'b1;
    // The pin only counts once power-off has been reached
    gap(1);
    on_pin();
    st(opm_pkg::OPM_ACTIVE);
    wr(opm_pkg::OPM_CMD_OFS, 32'h00000001, opm_pkg::OPM_RESP_OKAY);
    gap(2);
    st(opm_pkg::OPM_POWER_OFF);
    on_pin();
    on_pin();
    st(opm_pkg::OPM_POWER_OFF);
    on_pin();
    wr(opm_pkg::OPM_CTRL_OFS, 32'h00000001, opm_pkg::OPM_RESP_OKAY);
    busy <= 1'b1;
    ev(3);
    gap(2);
    st(opm_pkg::OPM_ACTIVE);
    busy <= 1'b0;
    ev(3);
    gap(2);
    st(opm_pkg::OPM_DEEP_SLEEP);
    wr(opm_pkg::OPM_CMD_OFS, 32'h00000001, opm_pkg::OPM_RESP_OKAY);
    gap(2);
    st(opm_pkg::OPM_DEEP_SLEEP);
    ev(4);
    gap(2);
    st(opm_pkg::OPM_ACTIVE);
    wr(opm_pkg::OPM_CTRL_OFS, 32'h00000010, opm_pkg::OPM_RESP_OKAY);
    ev(2);
    gap(2);
    st(opm_pkg::OPM_DEEP_SLEEP);
    ev(1);
    gap(2);
    st(opm_pkg::OPM_ACTIVE);
    wr(opm_pkg::OPM_CTRL_OFS, 32'h00000002, opm_pkg::OPM_RESP_OKAY);
    gap(GAP);
    st(opm_pkg::OPM_DEEP_SLEEP);
    on_pin();
    st(opm_pkg::OPM_ACTIVE);
    wr(opm_pkg::OPM_CTRL_OFS, 32'h00000006, opm_pkg::OPM_RESP_OKAY);
    dtr_on <= 1'b0;
    gap(2);
    st(opm_pkg::OPM_IDLE);
    dtr_on <= 1'b1;
    gap(2);
    st(opm_pkg::OPM_ACTIVE);
    wr(opm_pkg::OPM_CTRL_OFS, 32'h00000008, opm_pkg::OPM_RESP_OKAY);
    gap(GAP);
    st(opm_pkg::OPM_IDLE);
    ev(0);
    gap(45);
    ev(0);
    gap(3);
    chk_n(n_acc, 1);
    wr(opm_pkg::OPM_CTRL_OFS, 32'h00000000, opm_pkg::OPM_RESP_OKAY);
    radio <= 1'b1;
    gap(2);
    st(opm_pkg::OPM_CONNECTED);
    on_pin();
    st(opm_pkg::OPM_CONNECTED);
    supply_ok <= 1'b0;
    gap(2);
    st(opm_pkg::OPM_NOT_POWERED);
    results();
  end
endmodule
`default_nettype wire

/* pkg/opm_pkg.sv */
`default_nettype none
// Shared constants for the operating mode power sequencer
package opm_pkg;

  // One-hot operating states
  typedef enum logic [5:0] {
    OPM_NOT_POWERED = 6'h01,
    OPM_POWER_OFF   = 6'h02,
    OPM_DEEP_SLEEP  = 6'h04,
    OPM_IDLE        = 6'h08,
    OPM_ACTIVE      = 6'h10,
    OPM_CONNECTED   = 6'h20
  } opm_state_t;

  // Register byte offsets
  localparam logic [3:0] OPM_CTRL_OFS   = 4'h0;  // Power saving configuration
  localparam logic [3:0] OPM_CMD_OFS    = 4'h4;  // Command strobes
  localparam logic [3:0] OPM_STATUS_OFS = 4'h8;  // Live state and outputs

  // Control register fields
  localparam int OPM_CTRL_PSM_BIT   = 0;  // Power saving mode enable, active timer to deep-sleep
  localparam int OPM_CTRL_IDLE_LSB  = 1;  // Idle power config, 3 bits
  localparam int OPM_CTRL_IDLE_MSB  = 3;
  localparam int OPM_CTRL_EDRX_BIT  = 4;  // Deep-sleep variant allows eDRX sleep
  localparam int OPM_CTRL_WIDTH     = 5;
  localparam logic [4:0] OPM_CTRL_RESET = 5'h00;

  // Command register fields
  localparam int OPM_CMD_OFF_BIT = 0;  // Switch-off command

  // Status register fields
  localparam int OPM_STAT_STATE_LSB = 0;   // One-hot state, 6 bits
  localparam int OPM_STAT_WAKE_BIT  = 8;   // Wake-up completed
  localparam int OPM_STAT_IF_BIT    = 9;   // Application interfaces enabled

  // Idle power config values
  localparam logic [2:0] OPM_IDLE_OFF   = 3'h0;  // No idle power saving
  localparam logic [2:0] OPM_IDLE_DEEP  = 3'h1;  // Inactivity timer to deep-sleep
  localparam logic [2:0] OPM_IDLE_DTR   = 3'h3;  // Terminal-ready line controls idle
  localparam logic [2:0] OPM_IDLE_RXWK  = 3'h4;  // Inactivity to idle, serial wake

  // AXI responses
  localparam logic [1:0] OPM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] OPM_RESP_DECERR = 2'h3;

  // Timing
  localparam longint OPM_CLK_HZ       = 40000000;
  localparam longint OPM_INACT_TIME_S = 6;
  localparam longint OPM_INACT_CYCLES = OPM_INACT_TIME_S * OPM_CLK_HZ;
  localparam longint OPM_WAKE_TIME_NS = 1000;
  localparam longint OPM_WAKE_CYCLES  = (OPM_WAKE_TIME_NS * OPM_CLK_HZ + 999999999)
                                        / 1000000000;
  localparam int     OPM_INACT_W      = 28;
  localparam int     OPM_WAKE_W       = 6;

endpackage
`default_nettype wire
